// ### logic/accel_params.svh
// Constants for the accelerometer register bank: offsets, fields, resets.
// Assumes inclusion by bare name; the guard makes a repeat harmless.
`ifndef ACCEL_PARAMS_SVH
`define ACCEL_PARAMS_SVH

// Register offsets, two-wire numbering
`define X_HIGH_ADDR 4'h0
`define AUX_LOW_ADDR 4'h7
`define KEY_ADDR 4'ha
`define RBC_ADDR 4'hc
`define PSC_ADDR 4'hd
// Four-wire address bit that selects a read
`define SPI_READ_BIT 7
// Reload key pattern
`define CAL_KEY 8'hca
// Reset values and writable masks of the two control registers
`define RBC_RESET 8'he1
`define RBC_MASK 8'he3
`define PSC_RESET 8'h40
`define PSC_MASK 8'he0
// Field positions in the power register
`define PSC_STRETCH_BIT 7
`define PSC_ENABLE_BIT 6
`define PSC_SELFTEST_BIT 5
// Sensitivity in counts per g by range code
`define CNT_8G 10'd205
`define CNT_6G 10'd273
`define CNT_4G 10'd410
`define CNT_2G 10'd819
// Filter corners in Hz, zero meaning no filter
`define HZ_NONE 11'd0
`define HZ_2000 11'd2000
`define HZ_1000 11'd1000
`define HZ_500 11'd500
`define HZ_100 11'd100
`define HZ_50 11'd50

`endif

// ### logic/accel_pkg.sv
// Types and decode helpers shared by the accelerometer register bank.
// Assumes the constants header sits beside it.
package accel_pkg;
`include "accel_params.svh"

    // Whole state of the register bank
    typedef struct packed {
        logic [7:0] range_bw;
        logic [7:0] power_st;
        logic [3:0] ptr;
        logic rd_pend;
        logic [3:0] rd_ptr;
        logic [7:0] rd_data;
        logic rd_valid;
        logic cal_reload;
        logic por_pend;
        logic scl_o;
        logic scl_oe_n;
        logic [9:0] counts;
        logic [10:0] corner;
        logic st_active;
        logic standby;
    } bank_s;

    // Sensitivity for a range code
    function automatic logic [9:0] range_counts(input logic [1:0] code);
        case (code)
            2'b00: range_counts = `CNT_8G;
            2'b01: range_counts = `CNT_6G;
            2'b10: range_counts = `CNT_4G;
            default: range_counts = `CNT_2G;
        endcase
    endfunction

    // Filter corner for a bandwidth code
    function automatic logic [10:0] bw_corner(input logic [2:0] code);
        case (code)
            3'b000: bw_corner = `HZ_NONE;
            3'b100: bw_corner = `HZ_1000;
            3'b101: bw_corner = `HZ_500;
            3'b110: bw_corner = `HZ_100;
            3'b111: bw_corner = `HZ_50;
            default: bw_corner = `HZ_2000;
        endcase
    endfunction
endpackage

// ### logic/result_store.sv
// Small memory holding the latest conversion result of each channel.
// Assumes one writer and one reader per cycle; read data is registered.
`timescale 1ns/1ns
module result_store #(
    parameter int DEPTH = 4,
    parameter int WIDTH = 12
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_idx,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [$clog2(DEPTH)-1:0] rd_idx,
    output logic [WIDTH-1:0] rd_data
);
    // Entries and the read register in one record
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0] rdata;
    } store_s;

    store_s st_reg; // Current contents
    store_s st_next; // Next contents

    // Read returns the old word when it meets a write to the same entry
    always_comb begin
        st_next = st_reg;
        st_next.rdata = st_reg.mem[rd_idx];
        if (wr_en) begin
            st_next.mem[wr_idx] = wr_data;
        end
    end

    // Results read as zero until the first conversion lands
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rd_data = st_reg.rdata;
endmodule // result_store

// ### logic/accel_sensor_register_bank.sv
// Register bank of a three-axis accelerometer behind its serial front end.
// Assumes the front end hands over whole address and data bytes.
//
// Contract
// - X high byte holds result bits 11..4
// - X low byte holds bits 3..0 on top
// - Y result split into high and low bytes
// - Z result split into high and low bytes
// - Auxiliary result split into high, low bytes
// - Four-wire read address sets bit seven
// - Key write reloads calibration values
// - Calibration reload also happens after reset
// - Range control resets e1, bits 4..2 zero
// - Range code picks full scale and sensitivity
// - Bandwidth code picks filter corner
// - Power control resets 40, bits 4..0 zero
// - Self-test active when enabled and set
// - Enable bit low means low-power standby
// - Stretch bit holds two-wire clock during conversion
// - Control writes at bit seven clear
// - Four-wire address bit seven gives direction, MSB first; two-wire takes it from bus framing
// - Reads auto-increment through results then controls
`timescale 1ns/1ns
`include "accel_params.svh"
module accel_sensor_register_bank
    import accel_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic spi_mode, // High selects four-wire addressing
    input wire logic chip_select_n, // Four-wire select, active low
    input wire logic cmd_valid, // One-cycle pulse: address byte, and data if writing
    input wire logic cmd_write, // Two-wire direction from bus framing
    input wire logic [7:0] cmd_addr,
    input wire logic [7:0] cmd_wdata,
    input wire logic read_next, // One-cycle pulse: next byte of a read
    input wire logic conv_done, // One-cycle pulse: a result is ready
    input wire logic [1:0] conv_channel, // 0 x, 1 y, 2 z, 3 auxiliary
    input wire logic [11:0] conv_result,
    input wire logic conv_busy, // Conversion in progress
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic cal_reload,
    output logic [1:0] range_sel,
    output logic [9:0] counts_per_g,
    output logic [2:0] bandwidth_sel,
    output logic [10:0] corner_hz,
    output logic self_test_active,
    output logic standby
);
    bank_s s_reg; // Registered state
    bank_s s_next; // Next state
    logic [11:0] res_word; // Stored result for the pointed channel
    logic cs_ok; // Access allowed this cycle
    logic is_wr; // Access is a write
    logic [7:0] reg_addr; // Address with direction bit removed
    logic in_map; // Address falls in the four-bit map
    logic [3:0] fmt_ptr; // Register being formatted
    logic [7:0] fmt_byte; // Byte value of that register

    // Conversion results live in their own small memory
    // The store reads one pointer ahead so the byte is ready a cycle later
    result_store #(
        .DEPTH(4),
        .WIDTH(12)
    ) u_store (
        .clk_sys(clk_sys),
        .rst(rst),
        .wr_en(conv_done),
        .wr_idx(conv_channel),
        .wr_data(conv_result),
        .rd_idx(s_next.rd_ptr[2:1]),
        .rd_data(res_word)
    );

    // Auto-increment order: results, then range control, then power
    // Gap slots walk up to the controls; anything past them wraps
    function automatic logic [3:0] step_ptr(input logic [3:0] p);
        if (p == `AUX_LOW_ADDR) begin
            step_ptr = `RBC_ADDR;
        end else if (p >= `PSC_ADDR) begin
            step_ptr = `X_HIGH_ADDR; // Wraps to the start
        end else begin
            step_ptr = p + 4'h1;
        end
    endfunction

    // Address decode for both bus modes
    always_comb begin
        // Two-wire accesses count as always selected
        cs_ok = ~spi_mode | ~chip_select_n;
        if (spi_mode) begin
            is_wr = ~cmd_addr[`SPI_READ_BIT];
            reg_addr = {1'b0, cmd_addr[6:0]};
        end else begin
            // Two-wire framing already carried the direction
            is_wr = cmd_write;
            reg_addr = cmd_addr;
        end
        // Only the low sixteen addresses exist
        in_map = (reg_addr[7:4] == 4'h0);
    end

    // Byte format of the register read last cycle
    always_comb begin
        fmt_ptr = s_reg.rd_ptr;
        // Gap slots and parked reads fall through to zero
        fmt_byte = 8'h00;
        if (fmt_ptr <= `AUX_LOW_ADDR) begin
            // Odd offsets are low bytes, even ones high
            if (fmt_ptr[0]) begin
                fmt_byte = {res_word[3:0], 4'h0};
            end else begin
                fmt_byte = res_word[11:4];
            end
        // Controls read back as stored, reserved bits zero
        end else if (fmt_ptr == `RBC_ADDR) begin
            fmt_byte = s_reg.range_bw;
        end else if (fmt_ptr == `PSC_ADDR) begin
            fmt_byte = s_reg.power_st;
        end
    end

    // Next state of the whole bank
    always_comb begin
        s_next = s_reg;
        // Pulses last one cycle unless set again below
        s_next.cal_reload = 1'b0;
        s_next.rd_valid = 1'b0;
        s_next.rd_pend = 1'b0;
        // Power-up reload fires once after reset
        if (s_reg.por_pend) begin
            s_next.cal_reload = 1'b1;
            s_next.por_pend = 1'b0;
        end
        // Accesses from the front end
        if (cmd_valid && cs_ok) begin
            if (is_wr) begin
                // A wrong pattern is dropped without trace
                if (in_map && reg_addr[3:0] == `KEY_ADDR && cmd_wdata == `CAL_KEY) begin
                    s_next.cal_reload = 1'b1;
                end
                // Masking keeps reserved bits reading zero
                if (in_map && reg_addr[3:0] == `RBC_ADDR) begin
                    s_next.range_bw = cmd_wdata & `RBC_MASK;
                end
                // Stretch, enable and self-test share one byte
                if (in_map && reg_addr[3:0] == `PSC_ADDR) begin
                    s_next.power_st = cmd_wdata & `PSC_MASK;
                end
            end else begin
                // Off-map reads park on an empty slot that reads zero
                s_next.ptr = in_map ? reg_addr[3:0] : 4'hf;
                s_next.rd_ptr = s_next.ptr;
                s_next.rd_pend = 1'b1;
            end
        end else if (read_next && cs_ok) begin
            // Next byte walks on from the last pointer
            s_next.ptr = step_ptr(s_reg.ptr);
            s_next.rd_ptr = s_next.ptr;
            s_next.rd_pend = 1'b1;
        end
        // Read data leaves one cycle after the store answers
        if (s_reg.rd_pend) begin
            // Data then holds until the next answer
            s_next.rd_data = fmt_byte;
            s_next.rd_valid = 1'b1;
        end
        // Decoded controls follow the registers
        // Decoding the next value keeps outputs in step with the bits
        s_next.counts = range_counts(s_next.range_bw[1:0]);
        s_next.corner = bw_corner(s_next.range_bw[7:5]);
        s_next.st_active = s_next.power_st[`PSC_SELFTEST_BIT]
            & s_next.power_st[`PSC_ENABLE_BIT];
        s_next.standby = ~s_next.power_st[`PSC_ENABLE_BIT];
        // Clock held only in two-wire mode; it drops when conv_busy falls or the stretch bit clears
        s_next.scl_oe_n = ~(s_reg.power_st[`PSC_STRETCH_BIT] & ~spi_mode
            & conv_busy);
        // Only ever pulls low; the line's pull-up lifts it
        s_next.scl_o = 1'b0;
    end

    // Single state register with constant reset values
    // Reset leaves the power-up reload pending
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_reg <= '{
                range_bw: `RBC_RESET,
                power_st: `PSC_RESET,
                ptr: 4'h0,
                rd_pend: 1'b0,
                rd_ptr: 4'h0,
                rd_data: 8'h00,
                rd_valid: 1'b0,
                cal_reload: 1'b0,
                por_pend: 1'b1,
                scl_o: 1'b0,
                scl_oe_n: 1'b1,
                counts: `CNT_6G,
                corner: `HZ_50,
                st_active: 1'b0,
                standby: 1'b0
            };
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    // Control fields leave as the stored bits
    assign scl_o = s_reg.scl_o;
    assign scl_oe_n = s_reg.scl_oe_n;
    assign rd_data = s_reg.rd_data;
    assign rd_valid = s_reg.rd_valid;
    assign cal_reload = s_reg.cal_reload;
    assign range_sel = s_reg.range_bw[1:0];
    assign counts_per_g = s_reg.counts;
    assign bandwidth_sel = s_reg.range_bw[7:5];
    assign corner_hz = s_reg.corner;
    assign self_test_active = s_reg.st_active;
    assign standby = s_reg.standby;

    // Helper: marks the first cycle after reset
    // Used by the power-up reload check and the key-miss check
    logic first_reg;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            first_reg <= 1'b1;
        end else begin
            first_reg <= 1'b0;
        end
    end

    // Checks sample on the one system clock
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Access shapes used by the checks
    sequence seq_key_write;
        cmd_valid && cs_ok && is_wr && in_map && reg_addr[3:0] == `KEY_ADDR
            && cmd_wdata == `CAL_KEY;
    endsequence
    sequence seq_aux_low_step;
        !cmd_valid && read_next && cs_ok && s_reg.ptr == `AUX_LOW_ADDR;
    endsequence
    sequence seq_spi_y_read;
        cmd_valid && spi_mode && !chip_select_n && cmd_addr == 8'h82;
    endsequence
    sequence seq_spi_rbc_write;
        cmd_valid && spi_mode && !chip_select_n && cmd_addr == 8'h0c;
    endsequence

    // Shapes for the read path and the silent writes
    sequence seq_read_take;
        cmd_valid && cs_ok && !is_wr;
    endsequence
    // Answer two edges after the take
    sequence seq_read_answer;
        ##2 rd_valid;
    endsequence
    // Key write with a wrong pattern, away from the power-up pulse
    sequence seq_key_miss;
        cmd_valid && cs_ok && is_wr && in_map && reg_addr[3:0] == `KEY_ADDR
            && cmd_wdata != `CAL_KEY && !first_reg;
    endsequence
    // Four-wire access while deselected
    sequence seq_deselected;
        cmd_valid && spi_mode && chip_select_n;
    endsequence
    // Next-byte step from the power register
    sequence seq_psc_step;
        !cmd_valid && read_next && cs_ok && s_reg.ptr == `PSC_ADDR;
    endsequence

    // Register contents and decoded levels
    AST_RBC_RESERVED: assert property (s_reg.range_bw[4:2] == 3'b000)
        else $error("Range control reserved bits set");
    AST_PSC_RESERVED: assert property (s_reg.power_st[4:0] == 5'h00)
        else $error("Power control reserved bits set");
    AST_KEY_RELOAD: assert property (seq_key_write |=> cal_reload)
        else $error("Key write gave no reload");
    AST_POR_RELOAD: assert property (first_reg |=> cal_reload)
        else $error("No reload after reset");
    AST_SELFTEST: assert property (##1 self_test_active
        == (s_reg.power_st[5] && s_reg.power_st[6]))
        else $error("Self-test output wrong");
    AST_STANDBY: assert property (standby == !s_reg.power_st[6])
        else $error("Standby output wrong");
    AST_STRETCH: assert property (!scl_oe_n |-> $past(conv_busy)
        && !$past(spi_mode) && $past(s_reg.power_st[`PSC_STRETCH_BIT]))
        else $error("Clock held without cause");
    AST_RANGE_2G: assert property (range_sel == 2'b11 |-> counts_per_g == 10'd819)
        else $error("Wrong sensitivity for two g");
    AST_AUTOINC: assert property (seq_aux_low_step
        |-> ##2 rd_valid && rd_data == s_reg.range_bw)
        else $error("Auto-increment skipped range control");
    AST_SPI_READ: assert property (seq_spi_y_read |-> seq_read_answer)
        else $error("Four-wire read not answered");
    AST_SPI_WRITE: assert property (seq_spi_rbc_write
        |=> s_reg.range_bw == ($past(cmd_wdata) & 8'he3))
        else $error("Four-wire control write lost");

    // Read path: answers, byte layout, empty slots
    AST_READ_ANSWER: assert property (seq_read_take |-> seq_read_answer)
        else $error("Read not answered in two cycles");
    AST_LOW_BYTE: assert property (rd_valid && $past(s_reg.rd_ptr[0])
        && $past(s_reg.rd_ptr) <= `AUX_LOW_ADDR
        |-> rd_data == {$past(res_word[3:0]), 4'h0})
        else $error("Low byte layout wrong");
    AST_HIGH_BYTE: assert property (rd_valid && !$past(s_reg.rd_ptr[0])
        && $past(s_reg.rd_ptr) <= `AUX_LOW_ADDR |-> rd_data == $past(res_word[11:4]))
        else $error("High byte layout wrong");
    AST_CTRL_READ: assert property (rd_valid && $past(s_reg.rd_ptr) == `PSC_ADDR
        |-> rd_data == $past(s_reg.power_st))
        else $error("Power control read back wrong");
    AST_UNMAPPED: assert property (rd_valid && $past(s_reg.rd_ptr) > `AUX_LOW_ADDR
        && $past(s_reg.rd_ptr) != `RBC_ADDR && $past(s_reg.rd_ptr) != `PSC_ADDR
        |-> rd_data == 8'h00)
        else $error("Empty slot did not read zero");
    AST_PSC_WRAP: assert property (seq_psc_step |=> s_reg.ptr == `X_HIGH_ADDR)
        else $error("Chain did not wrap to the start");

    // Writes that must leave no trace
    AST_KEY_MISS: assert property (seq_key_miss |=> !cal_reload)
        else $error("Wrong key pattern reloaded");
    AST_DESELECT: assert property (seq_deselected |=> $stable(s_reg.range_bw)
        && $stable(s_reg.power_st))
        else $error("Deselected access changed a control");

    // Clock hold and power levels
    AST_NO_HOLD_SPI: assert property (spi_mode |=> scl_oe_n)
        else $error("Clock held in four-wire mode");
    AST_NO_HOLD_BIT: assert property (!s_reg.power_st[`PSC_STRETCH_BIT] |=> scl_oe_n)
        else $error("Clock held with stretch bit clear");
    AST_ST_ENABLED: assert property (self_test_active |-> !standby)
        else $error("Self-test active in standby");
endmodule // accel_sensor_register_bank

// ### verification/host_model.sv
// Host side model: hands whole accesses to the bank as the serial front end would.
// Assumes the bench owns spi_mode and the conversion inputs.
`timescale 1ns/1ns
module host_model (
    input wire logic clk_sys,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data,
    output logic chip_select_n,
    output logic cmd_valid,
    output logic cmd_write,
    output logic [7:0] cmd_addr,
    output logic [7:0] cmd_wdata,
    output logic read_next
);
    // Idle at time zero: deselected, nothing requested
    initial begin
        chip_select_n = 1'b1;
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_addr = 8'h00;
        cmd_wdata = 8'h00;
        read_next = 1'b0;
    end

    // One access held for exactly one edge; csn high means a deselected attempt
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] dt,
        input logic csn);
        @(negedge clk_sys);
        chip_select_n = csn;
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_addr = a;
        cmd_wdata = dt;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        // Released bytes flip so a stale value cannot pass as live
        cmd_addr = ~a;
        cmd_wdata = ~dt;
    endtask

    // Bounded wait for the answer byte; unknown when none arrives
    task automatic answer(output logic [7:0] dt);
        dt = 8'hxx;
        for (int i = 0; i < 6; i++) begin
            @(negedge clk_sys);
            if (rd_valid === 1'b1) begin
                dt = rd_data;
                break;
            end
        end
    endtask

    // Register write, selected
    task automatic wr(input logic [7:0] a, input logic [7:0] dt);
        access(1'b1, a, dt, 1'b0);
    endtask

    // Register read, selected
    task automatic rd(input logic [7:0] a, output logic [7:0] dt);
        access(1'b0, a, 8'h00, 1'b0);
        answer(dt);
    endtask

    // Next byte of an auto-increment read
    task automatic nxt(output logic [7:0] dt);
        @(negedge clk_sys);
        read_next = 1'b1;
        @(negedge clk_sys);
        read_next = 1'b0;
        answer(dt);
    endtask

    // End of a four-wire frame; the increment pointer stays where it was
    task automatic deselect();
        @(negedge clk_sys);
        chip_select_n = 1'b1;
    endtask
endmodule // host_model

// ### verification/accel_sensor_register_bank_tb_top.sv
// Bench for the accelerometer register bank, driven through the host model.
// Assumes the bank's own assertions guard cycle timing; this judges values.
`timescale 1ns/1ns
module accel_sensor_register_bank_tb_top;
    import accel_pkg::*;
    logic clk_sys, rst, spi_mode, conv_done, conv_busy, rd_valid, cal_reload;
    logic chip_select_n, cmd_valid, cmd_write, read_next, scl_o, scl_oe_n;
    logic self_test_active, standby;
    logic [1:0] conv_channel, range_sel;
    logic [2:0] bandwidth_sel;
    logic [7:0] cmd_addr, cmd_wdata, rd_data, d;
    logic [9:0] counts_per_g;
    logic [10:0] corner_hz;
    logic [11:0] conv_result;
    wire logic scl_i;
    int miscompares, n_compared, n;
    // Low nibbles nonzero so a leaking lower nibble shows
    logic [11:0] v [4] = '{12'hab1, 12'h3c2, 12'hf03, 12'h5e4};
    logic [9:0] cnt [4] = '{10'h0cd, 10'h111, 10'h19a, 10'h333};
    logic [10:0] hz [8] = '{11'h000, 11'h7d0, 11'h7d0, 11'h7d0, 11'h3e8, 11'h1f4,
        11'h064, 11'h032};

    // Clock line has a pull-up; only the device pulls it low
    assign scl_i = scl_oe_n ? 1'b1 : scl_o;

    accel_sensor_register_bank i_dut (.clk_sys(clk_sys), .rst(rst), .spi_mode(spi_mode),
        .chip_select_n(chip_select_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .read_next(read_next),
        .conv_done(conv_done), .conv_channel(conv_channel), .conv_result(conv_result),
        .conv_busy(conv_busy), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
        .rd_data(rd_data), .rd_valid(rd_valid), .cal_reload(cal_reload),
        .range_sel(range_sel), .counts_per_g(counts_per_g), .bandwidth_sel(bandwidth_sel),
        .corner_hz(corner_hz), .self_test_active(self_test_active), .standby(standby));

    host_model i_host (.clk_sys(clk_sys), .rd_valid(rd_valid), .rd_data(rd_data),
        .chip_select_n(chip_select_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .read_next(read_next));

    // 100 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Four-state compare, counted
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Byte expected at step i of the increment chain, wrapping after the controls
    function automatic logic [7:0] seq_byte(input int i);
        if (i % 10 == 8) return 8'he1;
        if (i % 10 == 9) return 8'h40;
        return (i % 2 == 0) ? v[(i % 10) / 2][11:4] : {v[(i % 10) / 2][3:0], 4'h0};
    endfunction

    // Counts reload pulses seen now and over the next three cycles
    task automatic count_reload();
        n = (cal_reload === 1'b1);
        repeat (3) begin
            @(negedge clk_sys);
            if (cal_reload === 1'b1) n++;
        end
    endtask

    // Reset values and the automatic reload after release
    task automatic t_reset();
        rst = 1'b1;
        repeat (10) @(negedge clk_sys);
        rst = 1'b0;
        @(negedge clk_sys);
        count_reload();
        check("power-up reload", 16'h0001, n[15:0]);
        check("range_sel", 2'b01, range_sel);
        check("bandwidth_sel", 3'b111, bandwidth_sel);
        check("counts_per_g", 10'h111, counts_per_g);
        check("corner_hz", 11'h032, corner_hz);
        check("standby", 1'b0, standby);
        check("scl_oe_n", 1'b1, scl_oe_n);
        i_host.rd(8'h8c, d);
        check("range control", 8'he1, d);
        i_host.rd(8'h8d, d);
        check("power control", 8'h40, d);
        $display("t_reset done");
    endtask

    // Results split into bytes, read through the increment chain
    task automatic t_results();
        for (int c = 0; c < 4; c++) begin
            @(negedge clk_sys);
            conv_done = 1'b1;
            conv_channel = c[1:0];
            conv_result = v[c];
            @(negedge clk_sys);
            conv_done = 1'b0;
        end
        i_host.wr(8'h02, 8'hff); // Result bytes ignore writes
        i_host.rd(8'h80, d);
        check("x high", v[0][11:4], d);
        for (int i = 1; i < 11; i++) begin
            i_host.nxt(d);
            check("chain byte", seq_byte(i), d);
        end
        i_host.deselect();
        i_host.rd(8'h82, d);
        check("y high", v[1][11:4], d);
        i_host.rd(8'h88, d);
        check("unmapped", 8'h00, d);
        i_host.rd(8'h90, d);
        check("beyond map", 8'h00, d);
        i_host.nxt(d);
        check("wrap after park", v[0][11:4], d);
        spi_mode = 1'b0;
        i_host.rd(8'h03, d);
        check("two-wire y low", {v[1][3:0], 4'h0}, d);
        spi_mode = 1'b1;
        $display("t_results done");
    endtask

    // Every range and bandwidth code, reserved bits forced to one
    task automatic t_ctrl();
        for (int r = 0; r < 4; r++) begin
            for (int b = 0; b < 8; b++) begin
                i_host.wr(8'h0c, {b[2:0], 3'b111, r[1:0]});
                check("range_sel", r[1:0], range_sel);
                check("counts_per_g", cnt[r], counts_per_g);
                check("bandwidth_sel", b[2:0], bandwidth_sel);
                check("corner_hz", hz[b], corner_hz);
            end
        end
        i_host.rd(8'h8c, d);
        check("range readback", 8'he3, d);
        i_host.access(1'b1, 8'h0c, 8'h00, 1'b1);
        check("deselected write", 2'b11, range_sel);
        spi_mode = 1'b0;
        i_host.wr(8'h0c, 8'he1);
        check("two-wire write", 2'b01, range_sel);
        spi_mode = 1'b1;
        $display("t_ctrl done");
    endtask

    // Enable, self-test and clock hold
    task automatic t_power();
        logic [7:0] pw [4] = '{8'h00, 8'h20, 8'h60, 8'h40};
        for (int i = 0; i < 4; i++) begin
            i_host.wr(8'h0d, pw[i]);
            check("standby", !pw[i][6], standby);
            check("self_test_active", pw[i][5] & pw[i][6], self_test_active);
        end
        i_host.wr(8'h0d, 8'hff);
        i_host.rd(8'h8d, d);
        check("power readback", 8'he0, d);
        spi_mode = 1'b0;
        i_host.wr(8'h0d, 8'hc0);
        conv_busy = 1'b1;
        @(negedge clk_sys);
        check("clock held", 1'b0, scl_i);
        spi_mode = 1'b1;
        @(negedge clk_sys);
        check("no hold four-wire", 1'b1, scl_oe_n);
        spi_mode = 1'b0;
        i_host.wr(8'h0d, 8'h40);
        @(negedge clk_sys);
        check("no hold, bit clear", 1'b1, scl_oe_n);
        conv_busy = 1'b0;
        i_host.wr(8'h0d, 8'h00);
        check("standby again", 1'b1, standby);
        spi_mode = 1'b1;
        $display("t_power done");
    endtask

    // Key pattern, a near-miss pattern and a neighbouring address
    task automatic t_key();
        logic [15:0] probe [3] = '{16'h0aca, 16'h0acb, 16'h0bca};
        for (int i = 0; i < 3; i++) begin
            i_host.wr(probe[i][15:8], probe[i][7:0]);
            count_reload();
            check("key reload", (i == 0), n[15:0]);
        end
        $display("t_key done");
    endtask

    // Prints counts and verdict, then ends the run
    task automatic test_done();
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Main sequence; inputs start defined at time zero
    initial begin
        rst = 1'b1;
        spi_mode = 1'b1;
        conv_done = 1'b0;
        conv_busy = 1'b0;
        conv_channel = 2'b00;
        conv_result = 12'h000;
        t_reset();
        t_results();
        t_ctrl();
        t_power();
        t_key();
        test_done();
    end

    // Hang guard, well beyond the fewer than two hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge clk_sys);
        miscompares++;
        test_done();
    end
endmodule // accel_sensor_register_bank_tb_top
